// ### fpes_host.sv
// Host controller: APB registers in, flash command sequences and status polling out.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fpes_host #(
   parameter int LOADWIN_CYC = fpes_pkg::LOADWIN_CYC,
   parameter int HWRST_CYC = fpes_pkg::HWRST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic [fpes_pkg::ADDR_W-1:0] flash_addr,
   output logic [fpes_pkg::DQ_W-1:0] flash_dq_out,
   output logic flash_dq_oe_n,
   input wire logic [fpes_pkg::DQ_W-1:0] flash_dq_in,
   output logic flash_reset_n,
   output logic protect_accel_pin,
   input wire logic ready_busy_n
);
   typedef enum logic [2:0] {S_IDLE, S_WRITE, S_READ, S_POLL_A, S_POLL_B, S_LOADWIN,
      S_HWRST} fpes_state_t;
   localparam int AW = fpes_pkg::ADDR_W;

   fpes_state_t state;
   fpes_pkg::fpes_op_t op;
   logic [AW-1:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic [15:0] poll_first;
   logic [2:0] idx;
   logic start;
   logic bypass;
   logic susp;
   logic susp_prog;
   logic erasing;
   logic done_flag;
   logic err_flag;
   logic refused_flag;
   logic etimer;
   logic accel;
   logic [31:0] timer;
   logic [31:0] rst_cnt;

   fpes_pkg::fpes_pins_t pins;
   logic [15:0] bc_rdata;
   logic bc_done;

   // Register access decode.
   wire logic acc = psel && penable && !pready;
   wire logic wr_acc = acc && pwrite;
   wire logic hit_cmd = paddr == fpes_pkg::REG_CMD;
   wire logic hit_addr = paddr == fpes_pkg::REG_ADDR;
   wire logic hit_wdata = paddr == fpes_pkg::REG_WDATA;
   wire logic hit_stat = paddr == fpes_pkg::REG_STATUS;
   wire logic hit_rdata = paddr == fpes_pkg::REG_RDATA;
   wire logic hit_cfg = paddr == fpes_pkg::REG_CFG;
   wire logic mapped = hit_cmd | hit_addr | hit_wdata | hit_stat | hit_rdata | hit_cfg;
   wire fpes_pkg::fpes_op_t new_op = fpes_pkg::fpes_op_t'(pwdata[3:0]);
   wire logic cmd_wr = wr_acc && hit_cmd;
   wire logic byp_eff = bypass | accel;

   // Which new operation may be launched from the present state.
   wire logic idle_ok = (state == S_IDLE) && (!byp_eff ?
      (new_op != fpes_pkg::OP_BYP_RESET) :
      (new_op == fpes_pkg::OP_PROGRAM || new_op == fpes_pkg::OP_BYP_RESET ||
      new_op == fpes_pkg::OP_READ)) &&
      (!susp || new_op == fpes_pkg::OP_PROGRAM || new_op == fpes_pkg::OP_READ ||
      new_op == fpes_pkg::OP_RESUME) && (new_op != fpes_pkg::OP_SUSPEND) &&
      (new_op != fpes_pkg::OP_SECTOR_ADD) && (new_op != fpes_pkg::OP_HW_RESET);
   // Only sector erase pairs or a suspend are sent in the load window, never a cancelling command.
   wire logic win_ok = (state == S_LOADWIN) &&
      (new_op == fpes_pkg::OP_SECTOR_ADD || new_op == fpes_pkg::OP_SUSPEND);
   // Polling reads stay allowed while a sector erase runs; only suspend reaches the device.
   wire logic poll_ok = (state == S_POLL_A || state == S_POLL_B) && erasing &&
      op == fpes_pkg::OP_SECTOR_ERASE && new_op == fpes_pkg::OP_SUSPEND;
   wire logic launch = cmd_wr && (idle_ok || win_ok || poll_ok) &&
      new_op != fpes_pkg::OP_HW_RESET;
   wire logic hw_launch = cmd_wr && new_op == fpes_pkg::OP_HW_RESET;
   wire logic refuse = cmd_wr && !launch && !hw_launch;

   // Sequence table; bank and sector bits come from the address register.
   function automatic fpes_pkg::fpes_step_t step_of(input fpes_pkg::fpes_op_t o,
      input logic [2:0] i, input logic byp, input logic [AW-1:0] a, input logic [15:0] d);
      fpes_pkg::fpes_step_t s;
      logic [11:0] lo;
      logic [7:0] c;
      logic fin;
      lo = fpes_pkg::UNLOCK_A1;
      c = 8'h00;
      fin = 1'b0;
      s.data = 16'h0000;
      // Unlock prefix shared by program outside bypass, erase and bypass entry.
      case (i)
         3'd0, 3'd3: c = fpes_pkg::CMD_UNLOCK1;
         3'd1, 3'd4: begin
            lo = fpes_pkg::UNLOCK_A2;
            c = fpes_pkg::CMD_UNLOCK2;
         end
         default: c = fpes_pkg::CMD_ERASE_SETUP;
      endcase
      case (o)
         fpes_pkg::OP_PROGRAM: begin
            if (byp) begin
               c = (i == 3'd0) ? fpes_pkg::CMD_PROGRAM : 8'h00;
               fin = i == 3'd1;
            end else begin
               if (i == 3'd2) c = fpes_pkg::CMD_PROGRAM;
               fin = i == 3'd3;
            end
         end
         fpes_pkg::OP_CHIP_ERASE: begin
            if (i == 3'd5) c = fpes_pkg::CMD_CHIP_ERASE;
            fin = i == 3'd5;
         end
         fpes_pkg::OP_SECTOR_ERASE: begin
            if (i == 3'd5) c = fpes_pkg::CMD_SECTOR_ERASE;
            fin = i == 3'd5;
         end
         fpes_pkg::OP_BYP_ENTER: begin
            if (i == 3'd2) c = fpes_pkg::CMD_BYPASS;
            fin = i == 3'd2;
         end
         fpes_pkg::OP_BYP_RESET: begin
            c = (i == 3'd0) ? fpes_pkg::CMD_BYP_RESET1 : fpes_pkg::CMD_BYP_RESET2;
            fin = i == 3'd1;
         end
         fpes_pkg::OP_SECTOR_ADD: begin
            c = fpes_pkg::CMD_SECTOR_ERASE;
            fin = 1'b1;
         end
         fpes_pkg::OP_SUSPEND: begin
            c = fpes_pkg::CMD_SUSPEND;
            fin = 1'b1;
         end
         fpes_pkg::OP_RESUME: begin
            c = fpes_pkg::CMD_RESUME;
            fin = 1'b1;
         end
         default: begin
            c = fpes_pkg::CMD_RESET;
            fin = 1'b1;
         end
      endcase
      // Upper address bits carry the bank; upper data bits are zero in command cycles.
      s.addr = {a[AW-1:12], lo};
      s.data = {8'h00, c};
      // The data cycle carries the full address; sector commands carry the sector bits with the low 12 bits zero.
      if ((o == fpes_pkg::OP_PROGRAM) && fin) begin
         s.addr = a;
         s.data = d;
      end else if (fin && (o == fpes_pkg::OP_SECTOR_ERASE || o == fpes_pkg::OP_SECTOR_ADD)) begin
         s.addr = {a[AW-1:12], 12'h000};
      end
      s.last = fin;
      return s;
   endfunction

   wire fpes_pkg::fpes_step_t cur = step_of(op, idx, byp_eff, addr_reg, wdata_reg);
   wire logic is_poll = state == S_POLL_A || state == S_POLL_B || state == S_READ;
   wire logic long_op = op == fpes_pkg::OP_PROGRAM || op == fpes_pkg::OP_CHIP_ERASE ||
      op == fpes_pkg::OP_RESET_CMD;
   wire logic toggling = poll_first[fpes_pkg::DQ_TOGGLE] != bc_rdata[fpes_pkg::DQ_TOGGLE];
   wire logic timer_end = timer == 32'(LOADWIN_CYC - 1);
   wire logic rst_end = rst_cnt == 32'(HWRST_CYC - 1);

   wire logic [31:0] status_word = {23'h0, state == S_LOADWIN, etimer, ready_busy_n, susp,
      byp_eff, refused_flag, err_flag, done_flag, state != S_IDLE};
   wire logic [31:0] rd_mux = hit_cmd ? {28'h0, op} : hit_addr ? 32'(addr_reg) :
      hit_wdata ? {16'h0, wdata_reg} : hit_stat ? status_word :
      hit_rdata ? {16'h0, rdata_reg} : hit_cfg ? {31'h0, accel} : 32'h0;

   fpes_bus_cycle u_cycle (
      .pclk(pclk),
      .presetn(presetn),
      .abort(hw_launch),
      .start(start),
      .is_write(!is_poll),
      .addr(is_poll ? addr_reg : cur.addr),
      .wdata(cur.data),
      .dq_in(flash_dq_in),
      .pins(pins),
      .rdata(bc_rdata),
      .done(bc_done)
   );

   assign flash_ce_n = pins.ce_n;
   assign flash_we_n = pins.we_n;
   assign flash_oe_n = pins.oe_n;
   assign flash_addr = pins.addr;
   assign flash_dq_out = pins.dq_out;
   assign flash_dq_oe_n = pins.dq_oe_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         addr_reg <= '0;
         wdata_reg <= 16'h0;
         accel <= 1'b0;
         protect_accel_pin <= 1'b0;
      end else begin
         pready <= acc;
         pslverr <= acc && !mapped;
         prdata <= (acc && !pwrite) ? rd_mux : 32'h0;
         if (wr_acc && hit_addr) addr_reg <= pwdata[AW-1:0];
         if (wr_acc && hit_wdata) wdata_reg <= pwdata[15:0];
         if (wr_acc && hit_cfg) accel <= pwdata[fpes_pkg::CFG_ACCEL];
         protect_accel_pin <= accel;
      end
   end

   // Sticky flags: a hardware event in the clearing cycle wins over the clear.
   wire logic clr = wr_acc && hit_stat;
   wire logic set_done = (state == S_POLL_B && bc_done && !toggling) ||
      (state == S_READ && bc_done) || (state == S_WRITE && bc_done && cur.last &&
      !long_op && op != fpes_pkg::OP_SECTOR_ERASE && op != fpes_pkg::OP_SECTOR_ADD) ||
      (state == S_HWRST && rst_end);
   wire logic set_err = state == S_POLL_B && bc_done && toggling &&
      poll_first[fpes_pkg::DQ_EXCEED] && bc_rdata[fpes_pkg::DQ_EXCEED];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_flag <= 1'b0;
         err_flag <= 1'b0;
         refused_flag <= 1'b0;
      end else begin
         done_flag <= set_done | (done_flag & !(clr & pwdata[fpes_pkg::ST_DONE]));
         err_flag <= set_err | (err_flag & !(clr & pwdata[fpes_pkg::ST_ERR]));
         refused_flag <= refuse | (refused_flag & !(clr & pwdata[fpes_pkg::ST_REFUSED]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         op <= fpes_pkg::OP_READ;
         idx <= 3'd0;
         start <= 1'b0;
         bypass <= 1'b0;
         susp <= 1'b0;
         susp_prog <= 1'b0;
         erasing <= 1'b0;
         etimer <= 1'b0;
         timer <= 32'h0;
         rst_cnt <= 32'h0;
         rdata_reg <= 16'h0;
         poll_first <= 16'h0;
         flash_reset_n <= 1'b1;
      end else begin
         start <= 1'b0;
         if (hw_launch) begin
            state <= S_HWRST;
            op <= fpes_pkg::OP_HW_RESET;
            rst_cnt <= 32'h0;
            flash_reset_n <= 1'b0;
            bypass <= 1'b0;
            susp <= 1'b0;
            erasing <= 1'b0;
         end else if (launch) begin
            op <= new_op;
            idx <= 3'd0;
            start <= 1'b1;
            state <= (new_op == fpes_pkg::OP_READ) ? S_READ : S_WRITE;
            susp_prog <= susp && new_op == fpes_pkg::OP_PROGRAM;
         end else begin
            case (state)
               S_WRITE: begin
                  if (bc_done) begin
                     if (!cur.last) begin
                        idx <= idx + 3'd1;
                        start <= 1'b1;
                     end else begin
                        case (op)
                           fpes_pkg::OP_BYP_ENTER: bypass <= 1'b1;
                           fpes_pkg::OP_BYP_RESET: bypass <= 1'b0;
                           fpes_pkg::OP_RESET_CMD: bypass <= 1'b0;
                           default: bypass <= bypass;
                        endcase
                        if (op == fpes_pkg::OP_SUSPEND) susp <= 1'b1;
                        if (op == fpes_pkg::OP_RESUME) susp <= 1'b0;
                        erasing <= op == fpes_pkg::OP_CHIP_ERASE ||
                           op == fpes_pkg::OP_SECTOR_ERASE ||
                           op == fpes_pkg::OP_SECTOR_ADD || op == fpes_pkg::OP_RESUME;
                        // The load window restarts when the bus cycle of each sector write completes.
                        if (op == fpes_pkg::OP_SECTOR_ERASE ||
                              op == fpes_pkg::OP_SECTOR_ADD) begin
                           state <= S_LOADWIN;
                           timer <= 32'h0;
                           etimer <= 1'b0;
                        end else if (op == fpes_pkg::OP_PROGRAM ||
                              op == fpes_pkg::OP_CHIP_ERASE ||
                              op == fpes_pkg::OP_RESUME) begin
                           state <= S_POLL_A;
                           start <= 1'b1;
                        end else begin
                           state <= S_IDLE;
                        end
                     end
                  end
               end
               S_LOADWIN: begin
                  timer <= timer + 32'h1;
                  if (timer_end) begin
                     state <= S_POLL_A;
                     op <= fpes_pkg::OP_SECTOR_ERASE;
                     start <= 1'b1;
                  end
               end
               S_POLL_A: begin
                  if (bc_done) begin
                     poll_first <= bc_rdata;
                     state <= S_POLL_B;
                     start <= 1'b1;
                  end
               end
               S_POLL_B: begin
                  if (bc_done) begin
                     rdata_reg <= bc_rdata;
                     etimer <= bc_rdata[fpes_pkg::DQ_ETIMER];
                     if (!toggling) begin
                        state <= S_IDLE;
                        erasing <= 1'b0;
                        susp <= susp_prog;
                     end else if (set_err) begin
                        // Exceeded limit: the bank keeps showing status until a reset command.
                        op <= fpes_pkg::OP_RESET_CMD;
                        idx <= 3'd0;
                        state <= S_WRITE;
                        start <= 1'b1;
                     end else begin
                        state <= S_POLL_A;
                        start <= 1'b1;
                     end
                  end
               end
               S_READ: begin
                  if (bc_done) begin
                     rdata_reg <= bc_rdata;
                     state <= S_IDLE;
                  end
               end
               S_HWRST: begin
                  rst_cnt <= rst_cnt + 32'h1;
                  if (rst_end) begin
                     flash_reset_n <= 1'b1;
                     state <= S_IDLE;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ### fpes_pkg.sv
// Package for the flash program/erase host controller: constants, operations and carriers.
package fpes_pkg;

   localparam int CLK_MHZ = 250;
   localparam int T_WE_NS = 35;
   localparam int T_RD_NS = 65;
   localparam int T_HWRST_NS = 500;
   localparam int T_LOADWIN_US = 50;
   localparam int WE_CYC = (T_WE_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
   localparam int HWRST_CYC = (T_HWRST_NS * CLK_MHZ + 999) / 1000;
   localparam int LOADWIN_CYC = T_LOADWIN_US * CLK_MHZ;

   localparam int ADDR_W = 23;
   localparam int DQ_W = 16;

   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_CFG = 8'h14;

   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERR = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_BYPASS = 4;
   localparam int ST_SUSP = 5;
   localparam int ST_RDY = 6;
   localparam int ST_ETIMER = 7;
   localparam int ST_WINDOW = 8;
   localparam int CFG_ACCEL = 0;

   localparam int DQ_EXCEED = 5;
   localparam int DQ_TOGGLE = 6;
   localparam int DQ_ETIMER = 3;

   localparam logic [11:0] UNLOCK_A1 = 12'h555;
   localparam logic [11:0] UNLOCK_A2 = 12'h2aa;
   localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_BYPASS = 8'h20;
   localparam logic [7:0] CMD_BYP_RESET1 = 8'h90;
   localparam logic [7:0] CMD_BYP_RESET2 = 8'h00;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_RESET = 8'hf0;

   typedef enum logic [3:0] {
      OP_READ,
      OP_PROGRAM,
      OP_CHIP_ERASE,
      OP_SECTOR_ERASE,
      OP_SECTOR_ADD,
      OP_BYP_ENTER,
      OP_BYP_RESET,
      OP_SUSPEND,
      OP_RESUME,
      OP_RESET_CMD,
      OP_HW_RESET
   } fpes_op_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] data;
      logic last;
   } fpes_step_t;

   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic dq_oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] dq_out;
   } fpes_pins_t;

endpackage

// ### fpes_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, timed in clock cycles.
`timescale 1ns/100ps
`default_nettype none
module fpes_bus_cycle #(
   parameter int WE_CYC = fpes_pkg::WE_CYC,
   parameter int RD_CYC = fpes_pkg::RD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic abort,
   input wire logic start,
   input wire logic is_write,
   input wire logic [fpes_pkg::ADDR_W-1:0] addr,
   input wire logic [fpes_pkg::DQ_W-1:0] wdata,
   input wire logic [fpes_pkg::DQ_W-1:0] dq_in,
   output fpes_pkg::fpes_pins_t pins,
   output logic [fpes_pkg::DQ_W-1:0] rdata,
   output logic done
);
   typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fpes_bc_t;
   fpes_bc_t state;
   logic [7:0] cnt;
   logic wr;
   wire logic [7:0] pulse_len = wr ? 8'(WE_CYC) : 8'(RD_CYC);
   wire logic strobe_end = (state == BC_STROBE) && (cnt == pulse_len - 8'h01);

   // Address is presented a cycle before the strobe falls so it is stable at the device's latch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= BC_IDLE;
         cnt <= 8'h00;
         wr <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
         pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1, addr: '0, dq_out: '0};
      end else if (abort) begin
         state <= BC_IDLE;
         done <= 1'b0;
         pins.ce_n <= 1'b1;
         pins.we_n <= 1'b1;
         pins.oe_n <= 1'b1;
         pins.dq_oe_n <= 1'b1;
      end else begin
         done <= 1'b0;
         case (state)
            BC_IDLE: begin
               if (start) begin
                  state <= BC_SETUP;
                  wr <= is_write;
                  pins.addr <= addr;
                  pins.dq_out <= wdata;
                  pins.ce_n <= 1'b0;
                  pins.dq_oe_n <= !is_write;
               end
            end
            BC_SETUP: begin
               state <= BC_STROBE;
               cnt <= 8'h00;
               pins.we_n <= !wr;
               pins.oe_n <= wr;
            end
            BC_STROBE: begin
               cnt <= cnt + 8'h01;
               if (strobe_end) begin
                  state <= BC_HOLD;
                  pins.we_n <= 1'b1;
                  pins.oe_n <= 1'b1;
                  if (!wr) begin
                     rdata <= dq_in;
                  end
               end
            end
            BC_HOLD: begin
               state <= BC_IDLE;
               pins.ce_n <= 1'b1;
               pins.dq_oe_n <= 1'b1;
               done <= 1'b1;
            end
            default: state <= BC_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### fpes_host_props.sv
// Checker of APB and flash strobe timing at the host controller's ports.
`timescale 1ns/100ps
`default_nettype none
module fpes_host_props #(parameter int HWRST_CYC = 8) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   input wire logic [fpes_pkg::ADDR_W-1:0] flash_addr,
   input wire logic [fpes_pkg::DQ_W-1:0] flash_dq_out,
   input wire logic flash_dq_oe_n,
   input wire logic flash_reset_n
);
   int rst_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rst_cnt <= 0;
      else rst_cnt <= flash_reset_n ? 0 : rst_cnt + 1;
   end
   sequence s_we_low;
      (!flash_we_n)[*8] ##1 !flash_we_n ##1 flash_we_n;
   endsequence
   a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_in_access: assert property (pready |-> psel && penable && $past(penable))
      else $error("pready outside access");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   a_we_pulse_len: assert property ($fell(flash_we_n) |-> s_we_low)
      else $error("write pulse length");
   a_we_inside_ce: assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && flash_oe_n)
      else $error("write strobe framing");
   a_hold_during_we: assert property (!flash_we_n && $past(!flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved");
   a_hw_reset_len: assert property ($rose(flash_reset_n) |-> rst_cnt == HWRST_CYC)
      else $error("hardware reset length");
endmodule
bind fpes_host fpes_host_props #(.HWRST_CYC(HWRST_CYC)) u_props (.pclk, .presetn, .psel,
   .penable, .prdata, .pready, .pslverr, .flash_ce_n, .flash_we_n, .flash_oe_n,
   .flash_addr, .flash_dq_out, .flash_dq_oe_n, .flash_reset_n);
`default_nettype wire

// ### fpes_flash_model.sv
// Behavioural flash device that answers the host controller's bus cycles.
`timescale 1ns/100ps
`default_nettype none
module fpes_flash_model #(parameter int BUSY_CYC = 40) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic accel,
   input wire logic [22:0] addr,
   input wire logic [15:0] dq,
   output logic [15:0] dq_rd,
   output logic rb_n
);
   logic [15:0] mem [16];
   logic [15:0] pd = 16'hffff;
   logic we_q = 1'b1, oe_q = 1'b1, tgl = 1'b0, byp = 1'b0;
   int busy = 0, step = 0;
   wire [7:0] d = dq[7:0];
   assign rb_n = busy == 0;
   initial for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
   always @(posedge clk) begin
      we_q <= we_n;
      oe_q <= oe_n;
      if (!oe_n && oe_q) tgl <= ~tgl;
      // A released bus flips every cycle so a late sample cannot look right.
      if (oe_n) dq_rd <= ~dq_rd;
      else if (busy > 0) dq_rd <= {8'h00, ~pd[7], tgl, 6'h0c};
      else dq_rd <= mem[addr[3:0]];
      if (!reset_n) begin
         busy <= 0;
         step <= 0;
      end else if (busy > 0) busy <= busy - 1;
      else if (we_n && !we_q && !ce_n) begin
         case (step)
            0: step <= (byp || accel) ? (d == 8'ha0 ? 3 : d == 8'h90 ? 7 : 0) : d == 8'haa;
            1: step <= d == 8'h55 ? 2 : 0;
            2: begin
               step <= d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
               if (d == 8'h20) byp <= 1'b1;
            end
            3: begin
               mem[addr[3:0]] <= mem[addr[3:0]] & dq;
               pd <= dq;
               busy <= BUSY_CYC;
               step <= 0;
            end
            4: step <= d == 8'haa ? 5 : 0;
            5: step <= d == 8'h55 ? 6 : 0;
            6: begin
               for (int i = 0; i < 16; i++) mem[i] <= 16'hffff;
               pd <= 16'hffff;
               busy <= (d == 8'h10 || d == 8'h30) ? BUSY_CYC : 0;
               step <= 0;
            end
            default: begin
               byp <= d != 8'h00;
               step <= 0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### test_flash_program_erase_sequencer.sv
// Self-checking bench for the flash program and erase host controller.
`timescale 1ns/100ps
`default_nettype none
module test_flash_program_erase_sequencer;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ce_n, we_n, oe_n, dq_oe_n, rst_n, accel, rb_n;
   logic [22:0] fa;
   logic [15:0] dq_o, dq_i;
   int fail_count = 0, cmp_count = 0;
   always #2 pclk = ~pclk;
   fpes_host #(.LOADWIN_CYC(50), .HWRST_CYC(8)) i_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_ce_n(ce_n),
      .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(fa), .flash_dq_out(dq_o),
      .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_i), .flash_reset_n(rst_n),
      .protect_accel_pin(accel), .ready_busy_n(rb_n));
   fpes_flash_model i_mem (.clk(pclk), .reset_n(rst_n), .ce_n, .we_n, .oe_n, .accel,
      .addr(fa), .dq(dq_oe_n ? dq_i : dq_o), .dq_rd(dq_i), .rb_n);
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      perr = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 20) begin
         chk("pready", 0, 1);
         end_of_test();
      end
   endtask
   task automatic wait_done(input int lim);
      int n = 0;
      do begin
         apb(0, fpes_pkg::REG_STATUS, 0);
         n++;
      end while (rd[fpes_pkg::ST_DONE] !== 1'b1 && n < lim);
      chk("done", rd[fpes_pkg::ST_DONE], 1);
      if (n >= lim) end_of_test();
      apb(1, fpes_pkg::REG_STATUS, 32'h0000000e);
   endtask
   task automatic op(input logic [3:0] o, input logic [22:0] a, input logic [15:0] d);
      apb(1, fpes_pkg::REG_ADDR, {9'h0, a});
      apb(1, fpes_pkg::REG_WDATA, {16'h0, d});
      apb(1, fpes_pkg::REG_CMD, {28'h0, o});
   endtask
   task automatic rd_word(input logic [22:0] a, input logic [15:0] exp);
      op(0, a, 0);
      wait_done(40);
      apb(0, fpes_pkg::REG_RDATA, 0);
      chk("array", rd, {16'h0, exp});
   endtask
   task automatic t_regs();
      apb(1, fpes_pkg::REG_CFG, 1);
      @(posedge pclk);
      chk("accel", accel, 1);
      apb(0, 8'h40, 0);
      chk("unmapped", {perr, rd[30:0]}, 32'h80000000);
      apb(1, fpes_pkg::REG_CFG, 0);
      $display("test regs done");
   endtask
   task automatic t_program();
      op(1, 23'h3, 16'h00f0);
      wait_done(40);
      rd_word(23'h3, 16'h00f0);
      op(1, 23'h3, 16'h0f0f);
      wait_done(40);
      rd_word(23'h3, 16'h0000);
      $display("test program done");
   endtask
   task automatic t_bypass(input logic acc);
      if (acc) apb(1, fpes_pkg::REG_CFG, 1);
      else op(5, 0, 0);
      if (!acc) wait_done(40);
      op(2, 0, 0);
      apb(0, fpes_pkg::REG_STATUS, 0);
      chk("refused", rd[fpes_pkg::ST_REFUSED], 1);
      chk("bypass", rd[fpes_pkg::ST_BYPASS], 1);
      apb(1, fpes_pkg::REG_STATUS, 32'h00000008);
      op(1, 23'h5, 16'h1234);
      wait_done(40);
      if (acc) apb(1, fpes_pkg::REG_CFG, 0);
      else op(6, 0, 0);
      if (!acc) wait_done(40);
      rd_word(23'h5, 16'h1234);
      $display("test bypass done");
   endtask
   task automatic t_erase();
      int n = 0;
      op(3, 23'h1000, 0);
      do begin
         apb(0, fpes_pkg::REG_STATUS, 0);
         n++;
      end while (rd[fpes_pkg::ST_WINDOW] !== 1'b1 && n < 40);
      chk("window", rd[fpes_pkg::ST_WINDOW], 1);
      op(4, 23'h2000, 0);
      apb(0, fpes_pkg::REG_STATUS, 0);
      chk("add refused", rd[fpes_pkg::ST_REFUSED], 0);
      wait_done(200);
      rd_word(23'h3, 16'hffff);
      op(2, 0, 0);
      op(10, 0, 0);
      wait_done(40);
      apb(0, fpes_pkg::REG_STATUS, 0);
      chk("ready", rd[fpes_pkg::ST_RDY], 1);
      $display("test erase done");
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_program();
      t_bypass(0);
      t_bypass(1);
      t_erase();
      end_of_test();
   end
endmodule
`default_nettype wire
